// [ocr_option_config_registers.sv]
// option configuration register bank: pin function select and write-once system options
//
// Strobed register access is this design's own decision.
`include "ocr_regs.svh"

module ocr_option_config_registers (
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire ocr_pkg::ocr_bus_req_s bus_req,
	output logic [7:0]                rdata,
	input  wire logic                 chan0_edge_level_b,
	input  wire logic                 chan0_edge_level_a,
	input  wire logic                 stop_exit_by_reset,
	output ocr_pkg::ocr_pin_mux_s     pin_mux,
	output ocr_pkg::ocr_sys_opt_s     sys_opt,
	output logic                      stop_opcode_illegal
);
	import ocr_pkg::*;

	// registered state and its next value
	ocr_state_s  state_ff;
	ocr_state_s  nxt_state;

	// address decode results
	logic        hit_sps;
	logic        hit_soo;

	// strobes qualified by the decode
	logic        wr_sps;
	logic        wr_soo;
	logic        rd_sps;
	logic        rd_soo;

	// write-once gate for the system option register
	logic        soo_write_open;
	logic        soo_write_take;

	// write data with unused bits masked off
	logic [7:0]  sps_wdata_masked;
	logic [7:0]  soo_wdata_masked;

	// read data chosen for the following cycle
	logic [7:0]  rdata_sel;

	// sync pin select fields
	logic        fld_sog_enable;
	logic        fld_hsync_enable;
	logic        fld_vsync_enable;

	// system option fields
	logic        fld_watchdog_disable;
	logic        fld_stop_enable;
	logic        fld_watchdog_rate;
	logic        fld_short_recovery;

	// timer channel claim on port E bit 0
	logic        timer_edge_level_any;

	// stop recovery choice
	logic        use_short_recovery;
	logic [12:0] recovery_cycles;

	// watchdog timeout choice
	logic [18:0] timeout_cycles;

	// address decode
	assign hit_sps = (bus_req.addr == `OCR_SYNC_PIN_SELECT_ADDR);
	assign hit_soo = (bus_req.addr == `OCR_SYSTEM_OPTION_ONCE_ADDR);

	// write strobes per register
	assign wr_sps = bus_req.wr && hit_sps;
	assign wr_soo = bus_req.wr && hit_soo;

	// read strobes per register
	assign rd_sps = bus_req.rd && hit_sps;
	assign rd_soo = bus_req.rd && hit_soo;

	// lock is open from reset until the first write, whatever its data
	assign soo_write_open = !state_ff.soo_locked;
	assign soo_write_take = wr_soo && soo_write_open;

	// unused bits never store, so they always read zero
	assign sps_wdata_masked = bus_req.wdata & `OCR_SPS_WMASK;
	assign soo_wdata_masked = bus_req.wdata & `OCR_SOO_WMASK;

	// read mux, unmapped addresses read zero
	always_comb begin
		rdata_sel = 8'h00;
		if (rd_sps) begin
			rdata_sel = state_ff.sps;
		end else if (rd_soo) begin
			rdata_sel = state_ff.soo;
		end
	end

	// next state: register writes, write-once lock, read data
	always_comb begin
		nxt_state = state_ff;
		if (wr_sps) begin
			nxt_state.sps = sps_wdata_masked;
		end
		// later writes are dropped silently until the next reset
		if (soo_write_take) begin
			nxt_state.soo        = soo_wdata_masked;
			nxt_state.soo_locked = 1'b1;
		end
		// read data stands for one cycle, then falls back to zero
		nxt_state.rdata = rdata_sel;
	end

	// state register with synchronous reset
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_ff.sps        <= `OCR_SPS_RESET;
			state_ff.soo        <= `OCR_SOO_RESET;
			state_ff.soo_locked <= 1'b0;
			state_ff.rdata      <= 8'h00;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// read data leaves straight from its flip-flops
	assign rdata = state_ff.rdata;

	// sync pin select fields
	assign fld_sog_enable   = state_ff.sps[`OCR_SPS_SOG_BIT];
	assign fld_hsync_enable = state_ff.sps[`OCR_SPS_HSYNC_BIT];
	assign fld_vsync_enable = state_ff.sps[`OCR_SPS_VSYNC_BIT];

	// system option fields
	assign fld_watchdog_disable = state_ff.soo[`OCR_SOO_WDOG_DIS_BIT];
	assign fld_stop_enable      = state_ff.soo[`OCR_SOO_STOP_EN_BIT];
	assign fld_watchdog_rate    = state_ff.soo[`OCR_SOO_WDOG_RATE_BIT];
	assign fld_short_recovery   = state_ff.soo[`OCR_SOO_SHORT_REC_BIT];

	// any nonzero edge/level select claims port E bit 0 for the timer
	assign timer_edge_level_any = chan0_edge_level_b || chan0_edge_level_a;

	// pin multiplexer controls
	always_comb begin
		pin_mux.hsync_out_enable     = fld_hsync_enable;
		pin_mux.vsync_out_enable     = fld_vsync_enable;
		pin_mux.sync_on_green_enable = fld_sog_enable;
		// sync-on-green wins over the timer channel
		pin_mux.pe0_timer_select     = !fld_sog_enable && timer_edge_level_any;
	end

	// a stop ended by reset never takes the short delay
	assign use_short_recovery = fld_short_recovery && !stop_exit_by_reset;

	// stop recovery length
	always_comb begin
		if (use_short_recovery) begin
			recovery_cycles = `OCR_REC_SHORT_CYC;
		end else begin
			recovery_cycles = `OCR_REC_LONG_CYC;
		end
	end

	// watchdog timeout length
	always_comb begin
		if (fld_watchdog_rate) begin
			timeout_cycles = `OCR_WDOG_SHORT_CYC;
		end else begin
			timeout_cycles = `OCR_WDOG_LONG_CYC;
		end
	end

	// system option levels, set by the first write and held until reset, with the recovery length also switched by stop_exit_by_reset
	always_comb begin
		sys_opt.short_stop_recovery     = fld_short_recovery;
		sys_opt.watchdog_rate_select    = fld_watchdog_rate;
		sys_opt.stop_enable             = fld_stop_enable;
		sys_opt.watchdog_disable        = fld_watchdog_disable;
		sys_opt.watchdog_enable         = !fld_watchdog_disable;
		sys_opt.stop_recovery_cycles    = recovery_cycles;
		sys_opt.watchdog_timeout_cycles = timeout_cycles;
	end

	// decoder treats the stop opcode as illegal unless enabled
	assign stop_opcode_illegal = !fld_stop_enable;
endmodule

// [ocr_regs.svh]
// register offsets, field positions, reset values and timing counts for the option registers
`ifndef OCR_REGS_SVH
`define OCR_REGS_SVH
`define OCR_SYNC_PIN_SELECT_ADDR     16'h001D
`define OCR_SYSTEM_OPTION_ONCE_ADDR  16'h001F
`define OCR_SPS_SOG_BIT              0
`define OCR_SPS_HSYNC_BIT            1
`define OCR_SPS_VSYNC_BIT            2
`define OCR_SOO_WDOG_DIS_BIT         0
`define OCR_SOO_STOP_EN_BIT          1
`define OCR_SOO_WDOG_RATE_BIT        2
`define OCR_SOO_SHORT_REC_BIT        3
`define OCR_SPS_RESET                8'h00
`define OCR_SOO_RESET                8'h00
`define OCR_SPS_WMASK                8'h07
`define OCR_SOO_WMASK                8'h0F
`define OCR_REC_SHORT_CYC            13'h0020
`define OCR_REC_LONG_CYC             13'h1000
`define OCR_WDOG_SHORT_CYC           19'h01FF0
`define OCR_WDOG_LONG_CYC            19'h3FFF0
`endif

// [ocr_pkg.sv]
// types shared by the option configuration register bank
package ocr_pkg;
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
	} ocr_bus_req_s;
	typedef struct packed {
		logic hsync_out_enable;
		logic vsync_out_enable;
		logic sync_on_green_enable;
		logic pe0_timer_select;
	} ocr_pin_mux_s;
	typedef struct packed {
		logic        short_stop_recovery;
		logic        watchdog_rate_select;
		logic        stop_enable;
		logic        watchdog_disable;
		logic        watchdog_enable;
		logic [12:0] stop_recovery_cycles;
		logic [18:0] watchdog_timeout_cycles;
	} ocr_sys_opt_s;
	typedef struct packed {
		logic [7:0] sps;
		logic [7:0] soo;
		logic       soo_locked;
		logic [7:0] rdata;
	} ocr_state_s;
endpackage

// [ocr_props.sv]
// option register assertions
`include "ocr_regs.svh"

module ocr_props (
	input wire logic                  clk,
	input wire logic                  rst_n,
	input wire ocr_pkg::ocr_bus_req_s bus_req,
	input wire logic [7:0]            rdata,
	input wire logic                  chan0_edge_level_b,
	input wire logic                  chan0_edge_level_a,
	input wire logic                  stop_exit_by_reset,
	input wire ocr_pkg::ocr_pin_mux_s pin_mux,
	input wire ocr_pkg::ocr_sys_opt_s sys_opt,
	input wire logic                  stop_opcode_illegal
);
	timeunit 1ns;
	timeprecision 1ps;
	import ocr_pkg::*;
	logic seen_wr_ff; // write-once register written since reset
	// remembers the first write to the write-once register
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			seen_wr_ff <= 1'b0;
		end else if (bus_req.wr && bus_req.addr == `OCR_SYSTEM_OPTION_ONCE_ADDR) begin
			seen_wr_ff <= 1'b1;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_rd_sps; bus_req.rd && bus_req.addr == `OCR_SYNC_PIN_SELECT_ADDR; endsequence
	sequence s_first_wr; !seen_wr_ff && bus_req.wr && bus_req.addr == `OCR_SYSTEM_OPTION_ONCE_ADDR; endsequence
	sequence s_late_wr; seen_wr_ff && bus_req.wr && bus_req.addr == `OCR_SYSTEM_OPTION_ONCE_ADDR; endsequence
	property p_rd_sps; s_rd_sps |=> rdata == {5'h00, pin_mux.vsync_out_enable, pin_mux.hsync_out_enable,
		pin_mux.sync_on_green_enable}; endproperty
	a_rd_sps: assert property (p_rd_sps) else $error("sync pin select readback wrong");
	property p_first; s_first_wr |=> sys_opt[36:33] == $past(bus_req.wdata[3:0]); endproperty
	a_first: assert property (p_first) else $error("first option write not taken");
	property p_late; s_late_wr |=> $stable(sys_opt[36:33]); endproperty
	a_late: assert property (p_late) else $error("later option write taken");
	property p_pe0; pin_mux.pe0_timer_select == (!pin_mux.sync_on_green_enable
		&& (chan0_edge_level_b || chan0_edge_level_a)); endproperty
	a_pe0: assert property (p_pe0) else $error("timer select wrong");
	property p_wdog; sys_opt.watchdog_enable != sys_opt.watchdog_disable; endproperty
	a_wdog: assert property (p_wdog) else $error("watchdog enable wrong");
	property p_rst; $rose(rst_n) |-> pin_mux[3:1] == 0 && sys_opt[36:33] == 0; endproperty
	a_rst: assert property (p_rst) else $error("rst");
	property p_rec; sys_opt[31:19] == (sys_opt[36] && !stop_exit_by_reset ? 32 : 4096); endproperty
	a_rec: assert property (p_rec) else $error("rec");
	property p_opt; sys_opt[18:0] == (sys_opt[35] ? 8176 : 262128) && stop_opcode_illegal != sys_opt[34]; endproperty
	a_opt: assert property (p_opt) else $error("opt");
endmodule
bind ocr_option_config_registers ocr_props u_chk (.clk, .rst_n, .bus_req, .rdata, .chan0_edge_level_b,
	.chan0_edge_level_a, .stop_exit_by_reset, .pin_mux, .sys_opt, .stop_opcode_illegal);

// [tb_top.sv]
// option register bench
module tb_top;
	timeunit 1ns / 1ps;
	import ocr_pkg::*;
	logic         clk = 0, rst_n = 0, lb = 0, la = 0, sx = 0, ill;
	logic [7:0]   rdata, d;
	integer       seed = 32'h6AA7C1A3, err_total = 0, n_checks = 0;
	ocr_bus_req_s bus_req = '0;
	ocr_pin_mux_s pin_mux;
	ocr_sys_opt_s sys_opt;
	always #2 clk = ~clk;
	ocr_option_config_registers dut (.clk, .rst_n, .bus_req, .rdata, .chan0_edge_level_b(lb), .chan0_edge_level_a(la),
		.stop_exit_by_reset(sx), .pin_mux, .sys_opt, .stop_opcode_illegal(ill));
	task chk(input logic [47:0] g, x);
		n_checks++;
		err_total += g !== x;
		if (g !== x) $display("mismatch %0t %h %h", $time, g, x);
	endtask
	task bus(input logic w, r, input logic [15:0] a, input logic [7:0] v);
		@(posedge clk) bus_req <= '{a, v, w, r};
		@(posedge clk) bus_req <= '0;
		#1;
	endtask
	function automatic logic [47:0] opt(logic [7:0] v, logic x);
		return {v[3:0], !v[0], v[3] && !x ? 13'h20 : 13'h1000, v[2] ? 19'h1FF0 : 19'h3FFF0, !v[1]};
	endfunction
	task final_report;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#20000 err_total++;
		final_report;
	end
	initial begin
		for (int i = 0; i < 8; i++) begin
			{lb, la, sx} <= 3'(i);
			repeat (3) @(posedge clk) rst_n <= 0;
			@(posedge clk) rst_n <= 1;
			#1;
			chk(pin_mux, {3'h0, i[2:1] != 0});
			chk({sys_opt, ill}, opt(8'h00, sx));
			d = i ? 8'($random(seed)) : 8'hFF;
			bus(1, 0, 16'h001D, d);
			chk(pin_mux, {d[1], d[2], d[0], !d[0] && i[2:1] != 0});
			bus(0, 1, 16'h001D, 0);
			chk(rdata, d & 8'h07);
			bus(1, 0, 16'h001F, d);
			bus(1, 0, 16'h001F, ~d);
			bus(0, 1, 16'h001F, 0);
			chk(rdata, d & 8'h0F);
			chk({sys_opt, ill}, opt(d, sx));
			bus(0, 1, 16'h0010, 0);
			chk(rdata, 0);
			$display("test %0d done", i);
		end
		final_report;
	end
endmodule
